// ===== hdl/core_sfr_defines.svh
`ifndef CORE_SFR_DEFINES_SVH
`define CORE_SFR_DEFINES_SVH
// special function register addresses
`define ADDR_BANK 8'h04
`define ADDR_WORK 8'h05
`define ADDR_PCL 8'h06
`define ADDR_TABLE_PTR_LOW 8'h07
`define ADDR_TABLE_READ_HIGH_BYTE 8'h08
`define ADDR_TABLE_PTR_HIGH 8'h09
`define ADDR_FLAGS 8'h0A
// flag register bit positions
`define FLAG_C 0
`define FLAG_AC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_PDF 4
`define FLAG_TO 5
// bank register field and reset values
`define BANK_BIT 0
`define BANK_RESET 1'b0
`define BANK_DIRECT 1'b0
`define BYTE_RESET 8'h00
`define FLAG_RESET 1'b0
`define PC_RESET 1'b0
`endif

// ===== hdl/core_sfr_pkg.sv
package core_sfr_pkg;
   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
      OP_RLC, OP_RRC, OP_INC, OP_DEC, OP_LOAD, OP_STORE, OP_TABRD,
      OP_CLRWDT, OP_HALT, OP_CALL
   } alu_op_e;
   typedef struct packed {
      logic valid;
      alu_op_e op;
      logic [7:0] addr;
      logic [7:0] operand;
   } cpu_op_s;
   typedef struct packed {
      logic wr;
      logic bank;
      logic [7:0] addr;
      logic [7:0] data;
   } mem_wr_s;
   typedef struct packed {
      logic c;
      logic ac;
      logic z;
      logic ov;
   } arith_flags_s;
   typedef struct packed {
      logic bank;
      logic [7:0] work;
      logic [7:0] table_ptr_low;
      logic [7:0] table_ptr_high;
      logic [7:0] table_read_high_byte;
      logic to;
      logic power_down_flag;
      arith_flags_s fl;
      logic rd_valid;
      logic [7:0] rd_data;
      mem_wr_s mem;
   } core_state_s;
endpackage : core_sfr_pkg

// ===== hdl/core_alu.sv
`timescale 1ns/1ps
`default_nettype none
module core_alu (
   // operation
   input wire core_sfr_pkg::alu_op_e op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   // result
   output logic [7:0] res,
   output core_sfr_pkg::arith_flags_s fl,
   output core_sfr_pkg::arith_flags_s upd
);
   logic [8:0] sum;
   logic [4:0] low;
   logic [7:0] low7;
   logic [7:0] bb;
   logic ci;
   logic is_sub;
   always_comb
   begin
      is_sub = (op == core_sfr_pkg::OP_SUB) || (op == core_sfr_pkg::OP_SBC);
      bb = is_sub ? ~b : b;
      // subtraction is a + ~b + 1, so carry out means no borrow
      ci = (op == core_sfr_pkg::OP_SUB) ? 1'b1 :
           (op == core_sfr_pkg::OP_ADD) ? 1'b0 : cin;
      sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
      low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      low7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
      res = 8'h00;
      fl = '0;
      upd = '0;
      case (op)
         core_sfr_pkg::OP_ADD, core_sfr_pkg::OP_ADC,
         core_sfr_pkg::OP_SUB, core_sfr_pkg::OP_SBC:
         begin
            res = sum[7:0];
            fl.c = sum[8];
            fl.ac = low[4];
            fl.ov = low7[7] ^ sum[8];
            upd = '1;
         end
         core_sfr_pkg::OP_AND, core_sfr_pkg::OP_OR, core_sfr_pkg::OP_XOR:
         begin
            res = (op == core_sfr_pkg::OP_AND) ? (a & b) :
                  (op == core_sfr_pkg::OP_OR) ? (a | b) : (a ^ b);
            upd.z = 1'b1;
         end
         core_sfr_pkg::OP_INC, core_sfr_pkg::OP_DEC:
         begin
            res = (op == core_sfr_pkg::OP_INC) ? b + 8'h01 : b - 8'h01;
            upd.z = 1'b1;
         end
         core_sfr_pkg::OP_RLC:
         begin
            res = {b[6:0], cin};
            fl.c = b[7];
            upd.c = 1'b1;
         end
         core_sfr_pkg::OP_RRC:
         begin
            res = {cin, b[7:1]};
            fl.c = b[0];
            upd.c = 1'b1;
         end
         default:
         begin
            res = 8'h00;
         end
      endcase
      fl.z = (res == 8'h00);
   end
endmodule : core_alu
`default_nettype wire

// ===== hdl/pc_page.sv
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.svh"
module pc_page #(
   parameter int PC_W = 11
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // control
   input wire logic step,
   input wire logic load,
   input wire logic [7:0] low,
   // state
   output logic [PC_W-1:0] pc,
   output logic dummy
);
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic dummy;
   } pc_state_s;
   pc_state_s st;
   pc_state_s next_st;
   generate
      if (PC_W < 9 || PC_W > 16)
      begin : g_bad_width
         $error("pc_page: PC_W must be 9 to 16");
      end
   endgenerate
   always_comb
   begin
      next_st = st;
      next_st.dummy = 1'b0;
      if (load)
      begin
         // only the low byte moves, so the jump stays in this page
         next_st.pc = {st.pc[PC_W-1:8], low};
         next_st.dummy = 1'b1;
      end
      else if (step)
      begin
         next_st.pc = st.pc + {{(PC_W-1){1'b0}}, 1'b1};
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         st <= '{pc: {PC_W{`PC_RESET}}, dummy: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end
   assign pc = st.pc;
   assign dummy = st.dummy;
   property p_page_jump;
      @(posedge core_clk) disable iff (!resetn)
      load |=> pc[PC_W-1:8] == $past(pc[PC_W-1:8]) && pc[7:0] == $past(low);
   endproperty
   a_page_jump: assert property (p_page_jump) else $error("pc load left page");
endmodule : pc_page
`default_nettype wire

// ===== hdl/cpu_core_special_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.svh"
module cpu_core_special_registers #(
   parameter int PC_W = 11,
   parameter int PROG_W = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // instruction issue
   input wire core_sfr_pkg::cpu_op_s op_in,
   output logic op_ready,
   // register reads
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic rd_valid,
   output logic [7:0] rd_data,
   // data memory writes
   output core_sfr_pkg::mem_wr_s mem_wr,
   output logic bank_select_bit,
   // program memory
   output logic [PC_W-1:0] pc,
   output logic [15:0] table_addr,
   input wire logic [PROG_W-1:0] prog_word,
   // watchdog events
   input wire logic wdt_timeout,
   input wire logic wdt_reset
);
   core_sfr_pkg::core_state_s st;
   core_sfr_pkg::core_state_s next_st;
   logic [7:0] alu_res;
   core_sfr_pkg::arith_flags_s alu_fl;
   core_sfr_pkg::arith_flags_s alu_upd;
   logic dummy;
   logic accept;
   logic wr_en;
   logic [7:0] wr_data;
   logic pcl_load;
   generate
      if (PROG_W < 9 || PROG_W > 16)
      begin : g_bad_prog
         $error("PROG_W must be 9 to 16");
      end
   endgenerate
   core_alu u_alu (
      .op(op_in.op),
      .a(st.work),
      .b(op_in.operand),
      .cin(st.fl.c),
      .res(alu_res),
      .fl(alu_fl),
      .upd(alu_upd)
   );
   // the dummy cycle refuses any new instruction
   assign op_ready = !dummy;
   assign accept = op_in.valid && op_ready;
   // destination writes: only single-source ops may target an address
   always_comb
   begin
      wr_en = 1'b0;
      wr_data = 8'h00;
      if (accept)
      begin
         case (op_in.op)
            core_sfr_pkg::OP_STORE:
            begin
               wr_en = 1'b1;
               wr_data = st.work;
            end
            core_sfr_pkg::OP_INC, core_sfr_pkg::OP_DEC:
            begin
               wr_en = 1'b1;
               wr_data = alu_res;
            end
            core_sfr_pkg::OP_TABRD:
            begin
               wr_en = 1'b1;
               wr_data = prog_word[7:0];
            end
            default:
            begin
               wr_en = 1'b0;
            end
         endcase
      end
   end
   assign pcl_load = wr_en && op_in.addr == `ADDR_PCL;
   pc_page #(
      .PC_W(PC_W)
   ) u_pc (
      .core_clk(core_clk),
      .resetn(resetn),
      .step(accept && !pcl_load),
      .load(pcl_load),
      .low(wr_data),
      .pc(pc),
      .dummy(dummy)
   );
   always_comb
   begin
      next_st = st;
      next_st.rd_valid = 1'b0;
      next_st.mem.wr = 1'b0;
      if (accept)
      begin
         case (op_in.op)
            core_sfr_pkg::OP_ADD, core_sfr_pkg::OP_ADC, core_sfr_pkg::OP_SUB,
            core_sfr_pkg::OP_SBC, core_sfr_pkg::OP_AND, core_sfr_pkg::OP_OR,
            core_sfr_pkg::OP_XOR, core_sfr_pkg::OP_RLC, core_sfr_pkg::OP_RRC:
            begin
               next_st.work = alu_res;
            end
            core_sfr_pkg::OP_LOAD:
            begin
               next_st.work = op_in.operand;
            end
            core_sfr_pkg::OP_TABRD:
            begin
               next_st.table_read_high_byte = 8'(prog_word[PROG_W-1:8]);
            end
            core_sfr_pkg::OP_CLRWDT:
            begin
               next_st.to = 1'b0;
               next_st.power_down_flag = 1'b0;
            end
            core_sfr_pkg::OP_HALT:
            begin
               next_st.to = 1'b0;
               next_st.power_down_flag = 1'b1;
            end
            default:
            begin
               // calls leave the flags alone
               next_st.work = st.work;
            end
         endcase
         // flags change in the same cycle as their result
         if (alu_upd.c)
            next_st.fl.c = alu_fl.c;
         if (alu_upd.ac)
            next_st.fl.ac = alu_fl.ac;
         if (alu_upd.z)
            next_st.fl.z = alu_fl.z;
         if (alu_upd.ov)
            next_st.fl.ov = alu_fl.ov;
      end
      // an explicit write to a flag bit beats the computed flag
      if (wr_en)
      begin
         case (op_in.addr)
            `ADDR_BANK: next_st.bank = wr_data[`BANK_BIT];
            `ADDR_WORK: next_st.work = wr_data;
            `ADDR_PCL: next_st.mem.wr = 1'b0;
            `ADDR_TABLE_PTR_LOW: next_st.table_ptr_low = wr_data;
            `ADDR_TABLE_PTR_HIGH: next_st.table_ptr_high = wr_data;
            `ADDR_TABLE_READ_HIGH_BYTE: next_st.table_read_high_byte = st.table_read_high_byte;
            `ADDR_FLAGS:
            begin
               // timeout and power-down bits are not writable
               next_st.fl.c = wr_data[`FLAG_C];
               next_st.fl.ac = wr_data[`FLAG_AC];
               next_st.fl.z = wr_data[`FLAG_Z];
               next_st.fl.ov = wr_data[`FLAG_OV];
            end
            default:
            begin
               next_st.mem.wr = 1'b1;
               next_st.mem.bank = `BANK_DIRECT;
               next_st.mem.addr = op_in.addr;
               next_st.mem.data = wr_data;
            end
         endcase
      end
      // a timeout in the cycle of a clear still sets the flag
      if (wdt_timeout)
         next_st.to = 1'b1;
      if (wdt_reset && !st.power_down_flag)
         next_st.bank = `BANK_RESET;
      if (rd_en)
      begin
         next_st.rd_valid = 1'b1;
         case (rd_addr)
            `ADDR_BANK: next_st.rd_data = {7'h00, st.bank};
            `ADDR_WORK: next_st.rd_data = st.work;
            `ADDR_PCL: next_st.rd_data = pc[7:0];
            `ADDR_TABLE_PTR_LOW: next_st.rd_data = st.table_ptr_low;
            `ADDR_TABLE_READ_HIGH_BYTE: next_st.rd_data = st.table_read_high_byte;
            `ADDR_TABLE_PTR_HIGH: next_st.rd_data = st.table_ptr_high;
            `ADDR_FLAGS: next_st.rd_data = {2'b00, st.to, st.power_down_flag, st.fl.ov, st.fl.z, st.fl.ac, st.fl.c};
            default: next_st.rd_data = 8'h00;
         endcase
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         st <= '0;
         st.bank <= `BANK_RESET;
         st.to <= `FLAG_RESET;
         st.power_down_flag <= `FLAG_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end
   assign rd_valid = st.rd_valid;
   assign rd_data = st.rd_data;
   assign mem_wr = st.mem;
   assign bank_select_bit = st.bank;
   assign table_addr = {st.table_ptr_high, st.table_ptr_low};
   // assertions
   sequence s_pcl_write;
      accept && pcl_load;
   endsequence
   sequence s_dummy_then_run;
      !op_ready ##1 op_ready;
   endsequence
   property p_dummy;
      @(posedge core_clk) disable iff (!resetn)
      s_pcl_write |=> s_dummy_then_run;
   endproperty
   a_dummy: assert property (p_dummy) else $error("no single dummy cycle");
   property p_bank_read;
      @(posedge core_clk) disable iff (!resetn)
      // the read returns the bank as it stood when the read was taken
      rd_en && rd_addr == `ADDR_BANK |=> rd_valid && rd_data == {7'h00, $past(bank_select_bit)};
   endproperty
   a_bank_read: assert property (p_bank_read) else $error("bank upper bits not zero");
   property p_bank_reset;
      @(posedge core_clk) disable iff (!resetn)
      $rose(resetn) |-> !bank_select_bit;
   endproperty
   a_bank_reset: assert property (p_bank_reset) else $error("bank not 0 after reset");
   property p_wdt_keep_bank;
      @(posedge core_clk) disable iff (!resetn)
      wdt_reset && st.power_down_flag && !(wr_en && op_in.addr == `ADDR_BANK) |=> $stable(bank_select_bit);
   endproperty
   a_wdt_keep_bank: assert property (p_wdt_keep_bank) else $error("bank lost in halt");
   property p_flag_protect;
      @(posedge core_clk) disable iff (!resetn)
      wr_en && op_in.addr == `ADDR_FLAGS && !wdt_timeout |=> $stable(st.to) && $stable(st.power_down_flag);
   endproperty
   a_flag_protect: assert property (p_flag_protect) else $error("flag write hit to/pdf");
   property p_halt;
      @(posedge core_clk) disable iff (!resetn)
      accept && op_in.op == core_sfr_pkg::OP_HALT && !wdt_timeout |=> st.power_down_flag && !st.to;
   endproperty
   a_halt: assert property (p_halt) else $error("halt flags wrong");
   property p_timeout_set;
      @(posedge core_clk) disable iff (!resetn)
      wdt_timeout |=> st.to;
   endproperty
   a_timeout_set: assert property (p_timeout_set) else $error("timeout flag not set");
   property p_add;
      @(posedge core_clk) disable iff (!resetn)
      accept && op_in.op == core_sfr_pkg::OP_ADD
      |=> {st.fl.c, st.work} == {1'b0, $past(st.work)} + {1'b0, $past(op_in.operand)}
          && st.fl.z == (st.work == 8'h00);
   endproperty
   a_add: assert property (p_add) else $error("add result or flags wrong");
   property p_direct_bank0;
      @(posedge core_clk) disable iff (!resetn)
      mem_wr.wr |-> mem_wr.bank == `BANK_DIRECT && mem_wr.addr == $past(op_in.addr);
   endproperty
   a_direct_bank0: assert property (p_direct_bank0) else $error("direct write off bank 0");
   property p_tabrd;
      @(posedge core_clk) disable iff (!resetn)
      accept && op_in.op == core_sfr_pkg::OP_TABRD && op_in.addr != `ADDR_TABLE_READ_HIGH_BYTE
      |=> st.table_read_high_byte == $past(prog_word[PROG_W-1:8]);
   endproperty
   a_tabrd: assert property (p_tabrd) else $error("table high byte wrong");
   property p_call;
      @(posedge core_clk) disable iff (!resetn)
      accept && op_in.op == core_sfr_pkg::OP_CALL && !wdt_timeout
      |=> $stable(st.fl) && $stable(st.to) && $stable(st.power_down_flag);
   endproperty
   a_call: assert property (p_call) else $error("call changed flags");
endmodule : cpu_core_special_registers
`default_nettype wire

// ===== verif/test_cpu_core_special_registers.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_core_special_registers;
   localparam int PCW = 11;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   core_sfr_pkg::cpu_op_s op_in = '0;
   logic rd_en = 1'b0;
   logic [7:0] rd_addr = 8'h00;
   logic [15:0] prog_word = 16'h0000;
   logic wdt_timeout = 1'b0;
   logic wdt_reset = 1'b0;
   logic op_ready;
   logic rd_valid;
   logic bank_select_bit;
   logic [7:0] rd_data;
   core_sfr_pkg::mem_wr_s mem_wr;
   logic [PCW-1:0] pc;
   logic [15:0] table_addr;
   // reference model
   logic [7:0] w = 8'h00;
   logic cm = 1'b0;
   logic acm = 1'b0;
   logic zm = 1'b0;
   logic ovm = 1'b0;
   logic tom = 1'b0;
   logic pdfm = 1'b0;
   logic [PCW-1:0] pcm = '0;
   int fails = 0;
   int n_compared = 0;
   core_sfr_pkg::alu_op_e ops [10] = '{core_sfr_pkg::OP_ADD, core_sfr_pkg::OP_ADC, core_sfr_pkg::OP_SUB,
      core_sfr_pkg::OP_SBC, core_sfr_pkg::OP_AND, core_sfr_pkg::OP_OR, core_sfr_pkg::OP_XOR,
      core_sfr_pkg::OP_RLC, core_sfr_pkg::OP_RRC, core_sfr_pkg::OP_LOAD};

   always #25 core_clk = ~core_clk;

   cpu_core_special_registers #(.PC_W(PCW), .PROG_W(16)) dut (
      .core_clk(core_clk),
      .resetn(resetn),
      .op_in(op_in),
      .op_ready(op_ready),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_valid(rd_valid),
      .rd_data(rd_data),
      .mem_wr(mem_wr),
      .bank_select_bit(bank_select_bit),
      .pc(pc),
      .table_addr(table_addr),
      .prog_word(prog_word),
      .wdt_timeout(wdt_timeout),
      .wdt_reset(wdt_reset)
   );

   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   task chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   function logic [7:0] fl();
      return {2'b00, tom, pdfm, ovm, zm, acm, cm};
   endfunction : fl

   task automatic alu(input core_sfr_pkg::alu_op_e op, input logic [7:0] b);
      logic [8:0] r;
      logic [4:0] h;
      logic [7:0] l;
      logic ci;
      logic [7:0] bb;
      ci = (op == core_sfr_pkg::OP_SUB) | ((op == core_sfr_pkg::OP_ADC || op == core_sfr_pkg::OP_SBC) & cm);
      bb = (op == core_sfr_pkg::OP_SUB || op == core_sfr_pkg::OP_SBC) ? ~b : b;
      r = {1'b0, w} + {1'b0, bb} + 9'(ci);
      h = {1'b0, w[3:0]} + {1'b0, bb[3:0]} + 5'(ci);
      l = {1'b0, w[6:0]} + {1'b0, bb[6:0]} + 8'(ci);
      case (op)
         core_sfr_pkg::OP_ADD, core_sfr_pkg::OP_ADC, core_sfr_pkg::OP_SUB, core_sfr_pkg::OP_SBC:
         begin
            cm = r[8];
            acm = h[4];
            ovm = l[7] ^ r[8];
            w = r[7:0];
            zm = (w == 8'h00);
         end
         core_sfr_pkg::OP_AND, core_sfr_pkg::OP_OR, core_sfr_pkg::OP_XOR:
         begin
            w = (op == core_sfr_pkg::OP_AND) ? (w & b) : (op == core_sfr_pkg::OP_OR) ? (w | b) : (w ^ b);
            zm = (w == 8'h00);
         end
         core_sfr_pkg::OP_RLC:
         begin
            w = {b[6:0], cm};
            cm = b[7];
         end
         core_sfr_pkg::OP_RRC:
         begin
            w = {cm, b[7:1]};
            cm = b[0];
         end
         core_sfr_pkg::OP_LOAD: w = b;
         default: ;
      endcase
   endtask : alu

   // called at edge plus 5; valid is left up so back-to-back issues assign it once per step
   task issue(input core_sfr_pkg::alu_op_e op, input logic [7:0] a, input logic [7:0] b, input bit take);
      op_in = '{1'b1, op, a, b};
      @(posedge core_clk);
      #5;
      if (take)
      begin
         pcm = pcm + 1'b1;
         alu(op, b);
      end
   endtask : issue

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      op_in.valid = 1'b0;
      rd_en = 1'b1;
      rd_addr = a;
      @(posedge core_clk);
      #5;
      chk({rd_valid, rd_data}, {1'b1, exp});
   endtask : rd_chk

   task pulse(input bit rst);
      if (rst)
         wdt_reset = 1'b1;
      else
         wdt_timeout = 1'b1;
      @(posedge core_clk);
      #5;
      wdt_reset = 1'b0;
      wdt_timeout = 1'b0;
   endtask : pulse

   initial
   begin
      repeat (20000) @(posedge core_clk);
      fails++;
      wrap_up();
   end

   initial
   begin
      logic [7:0] b;
      logic [15:0] pw;
      core_sfr_pkg::alu_op_e op;
      void'($urandom(32'hB9E7));
      repeat (20) @(posedge core_clk);
      #5;
      resetn = 1'b1;
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h0A, 8'h00);
      rd_chk(8'h30, 8'h00);
      chk(op_ready, 24'h000001);
      // random arithmetic, every result and flag set compared
      for (int k = 0; k < 300; k++)
      begin
         b = 8'($urandom);
         op = ops[$urandom % 10];
         issue(op, 8'h00, b, 1);
         rd_chk(8'h05, w);
         rd_chk(8'h0A, fl());
      end
      chk(pc, pcm);
      // bank selector and direct memory writes
      issue(core_sfr_pkg::OP_LOAD, 8'h00, 8'hFF, 1);
      issue(core_sfr_pkg::OP_STORE, 8'h04, 8'h00, 1);
      rd_chk(8'h04, 8'h01);
      chk(bank_select_bit, 24'h000001);
      issue(core_sfr_pkg::OP_STORE, 8'h50, 8'h00, 1);
      chk(mem_wr, {1'b1, 1'b0, 8'h50, 8'hFF});
      rd_chk(8'h05, 8'hFF);
      chk(mem_wr.wr, 24'h000000);
      pulse(0);
      tom = 1'b1;
      rd_chk(8'h0A, fl());
      issue(core_sfr_pkg::OP_HALT, 8'h00, 8'h00, 1);
      tom = 1'b0;
      pdfm = 1'b1;
      rd_chk(8'h0A, fl());
      // watchdog reset while powered down keeps the bank
      pulse(1);
      rd_chk(8'h04, 8'h01);
      pulse(0);
      tom = 1'b1;
      issue(core_sfr_pkg::OP_LOAD, 8'h00, 8'hC5, 1);
      issue(core_sfr_pkg::OP_STORE, 8'h0A, 8'h00, 1);
      {ovm, zm, acm, cm} = 4'h5;
      rd_chk(8'h0A, fl());
      issue(core_sfr_pkg::OP_CALL, 8'h00, 8'h00, 1);
      rd_chk(8'h0A, fl());
      issue(core_sfr_pkg::OP_CLRWDT, 8'h00, 8'h00, 1);
      tom = 1'b0;
      pdfm = 1'b0;
      issue(core_sfr_pkg::OP_LOAD, 8'h00, 8'hFF, 1);
      issue(core_sfr_pkg::OP_STORE, 8'h0A, 8'h00, 1);
      {ovm, zm, acm, cm} = 4'hF;
      rd_chk(8'h0A, fl());
      pulse(1);
      rd_chk(8'h04, 8'h00);
      // table pointers wrap under increment and decrement
      issue(core_sfr_pkg::OP_INC, 8'h07, 8'hFF, 1);
      zm = 1'b1;
      issue(core_sfr_pkg::OP_DEC, 8'h09, 8'h00, 1);
      zm = 1'b0;
      rd_chk(8'h0A, fl());
      chk(table_addr, 24'h00FF00);
      pw = 16'($urandom);
      prog_word = pw;
      issue(core_sfr_pkg::OP_TABRD, 8'h60, 8'h00, 1);
      chk(mem_wr, {1'b1, 1'b0, 8'h60, pw[7:0]});
      rd_chk(8'h08, pw[15:8]);
      // pc low write: in-page jump, then one refused cycle
      b = 8'($urandom);
      issue(core_sfr_pkg::OP_LOAD, 8'h00, b, 1);
      issue(core_sfr_pkg::OP_STORE, 8'h06, 8'h00, 1);
      pcm = {pcm[PCW-1:8], b};
      chk(pc, pcm);
      chk(op_ready, 24'h000000);
      issue(core_sfr_pkg::OP_LOAD, 8'h00, ~b, 0);
      chk(op_ready, 24'h000001);
      rd_chk(8'h05, b);
      // mid-run reset with bank 1 and power-down set must clear both
      issue(core_sfr_pkg::OP_LOAD, 8'h00, 8'h01, 1);
      issue(core_sfr_pkg::OP_STORE, 8'h04, 8'h00, 1);
      issue(core_sfr_pkg::OP_HALT, 8'h00, 8'h00, 1);
      tom = 1'b0;
      pdfm = 1'b1;
      rd_chk(8'h0A, fl());
      rd_chk(8'h04, 8'h01);
      resetn = 1'b0;
      repeat (2) @(posedge core_clk);
      #5;
      chk({rd_valid, bank_select_bit, pc}, 24'h000000);
      resetn = 1'b1;
      w = 8'h00;
      {ovm, zm, acm, cm} = 4'h0;
      tom = 1'b0;
      pdfm = 1'b0;
      pcm = '0;
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h0A, fl());
      rd_chk(8'h05, w);
      chk(pc, pcm);
      chk(op_ready, 24'h000001);
      // read answer lasts one cycle, data holds
      rd_en = 1'b0;
      @(posedge core_clk);
      #5;
      chk({rd_valid, rd_data}, 24'h000000);
      wrap_up();
   end
endmodule : test_cpu_core_special_registers
`default_nettype wire
